/* rtl/register_privilege_checker.sv */
// Privilege checker between instruction decode and trap sequencing.
// Assumes decode presents one request a cycle on mclk, with the stack
// pointer already settled, and a register port driven on the same clock.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module register_privilege_checker (
    // Clock and reset.
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    // Processor state.
    input  wire logic                         supervisor_flag,
    input  wire logic [7:0]                   stack_ptr,
    input  wire logic                         halt_debug_exempt,
    // Decode request.
    input  wire priv_check_pkg::decode_req_t  req,
    // Verdict to trap logic.
    output priv_check_pkg::verdict_t          verdict,
    // Register port.
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic [31:0]                       reg_rdata,
    // Interrupt.
    output logic                              irq
);

    logic [15:0] bank_guard_bits;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic [15:0] viol_count;
    logic        halt_exempt_sw;

    // Absolute register number of one operand.
    function automatic logic [7:0] abs_num(input priv_check_pkg::gpr_ref_t r,
                                           input logic [7:0] sp);
        logic [7:0] rel;
        rel = {1'b0, r.num};
        if (r.is_local) begin
            abs_num = 8'((rel + sp) % 8'h80) | priv_check_pkg::local_base;
        end else begin
            abs_num = rel;
        end
    endfunction

    // True when a used operand at or above gpr_first falls in a guarded bank.
    function automatic logic guarded(input priv_check_pkg::gpr_ref_t r,
                                     input logic [7:0] sp,
                                     input logic [15:0] g);
        logic [7:0] a;
        a = abs_num(r, sp);
        guarded = r.used && (a >= priv_check_pkg::gpr_first)
                  && g[a[priv_check_pkg::bank_msb:priv_check_pkg::bank_lsb]];
    endfunction

    // Combinational violation terms for the current request.
    logic user_mode;
    logic gpr_viol;
    logic spr_viol;
    logic op_viol;
    logic vect_viol;
    logic any_viol;
    logic halt_free;

    always_comb begin
        user_mode = ~supervisor_flag;
        halt_free = halt_debug_exempt | halt_exempt_sw;
        // Supervisor accesses ignore the guard entirely.
        gpr_viol = user_mode && (guarded(req.src_a, stack_ptr, bank_guard_bits)
                              || guarded(req.src_b, stack_ptr, bank_guard_bits)
                              || guarded(req.dst, stack_ptr, bank_guard_bits));
        spr_viol = req.spr_used
                   && ((req.spr_num >= priv_check_pkg::spr_virt_min)
                       || (user_mode
                           && req.spr_num <= priv_check_pkg::spr_user_max));
        op_viol = 1'b0;
        if (user_mode) begin
            case (req.op)
                priv_check_pkg::op_int_ret,
                priv_check_pkg::op_ret_inv,
                priv_check_pkg::op_inval: op_viol = 1'b1;
                priv_check_pkg::op_halt:  op_viol = ~halt_free;
                default:                  op_viol = 1'b0;
            endcase
        end
        vect_viol = user_mode && req.op == priv_check_pkg::op_trap_vec
                    && req.vector <= priv_check_pkg::vector_user_max;
        any_viol = req.valid && (gpr_viol || spr_viol || op_viol || vect_viol);
    end

    // Registered verdict; a trap withholds commit of the instruction.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            verdict <= '0;
        end else begin
            verdict.valid  <= req.valid;
            verdict.trap   <= any_viol;
            verdict.commit <= req.valid && !any_viol;
        end
    end

    // Bank guard register; upper half is reserved and reads zero.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_guard_bits <= priv_check_pkg::bank_guard_reset;
        end else if (reg_wr && reg_addr == priv_check_pkg::gpr_bank_guard_idx) begin
            bank_guard_bits <= reg_wdata[15:0];
        end
    end

    // Mask and halt exemption controls.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask       <= priv_check_pkg::irq_reset;
            halt_exempt_sw <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == priv_check_pkg::irq_mask_idx) begin
                irq_mask <= reg_wdata[3:0];
            end
            if (reg_addr == priv_check_pkg::halt_exempt_idx) begin
                halt_exempt_sw <= reg_wdata[0];
            end
        end
    end

    // Sticky status; a new event wins over a write-one clear.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= priv_check_pkg::irq_reset;
        end else begin
            logic [3:0] clr;
            logic [3:0] set;
            clr = (reg_wr && reg_addr == priv_check_pkg::irq_status_idx)
                  ? reg_wdata[3:0] : 4'h0;
            set = '0;
            set[priv_check_pkg::irq_gpr]  = req.valid && gpr_viol;
            set[priv_check_pkg::irq_spr]  = req.valid && spr_viol;
            set[priv_check_pkg::irq_op]   = req.valid && op_viol;
            set[priv_check_pkg::irq_vect] = req.valid && vect_viol;
            irq_status <= (irq_status & ~clr) | set;
        end
    end

    // Saturating count of trapped instructions.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            viol_count <= 16'h0000;
        end else if (reg_wr && reg_addr == priv_check_pkg::viol_count_idx) begin
            viol_count <= 16'h0000;
        end else if (any_viol && viol_count != 16'hffff) begin
            viol_count <= viol_count + 16'h0001;
        end
    end

    // Level interrupt from any unmasked status bit.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Read data, one cycle after the read strobe, zero otherwise.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                priv_check_pkg::gpr_bank_guard_idx:
                    reg_rdata <= {16'h0000, bank_guard_bits};
                priv_check_pkg::irq_status_idx:
                    reg_rdata <= {28'h0000000, irq_status};
                priv_check_pkg::irq_mask_idx:
                    reg_rdata <= {28'h0000000, irq_mask};
                priv_check_pkg::viol_count_idx:
                    reg_rdata <= {16'h0000, viol_count};
                priv_check_pkg::halt_exempt_idx:
                    reg_rdata <= {31'h00000000, halt_exempt_sw};
                default:
                    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

/* rtl/priv_check_pkg.sv */
// Constants and carrier types for the register privilege checker.
// Assumes a single 125 MHz clock and a plain strobe register port.
package priv_check_pkg;

    // Register map, word indices; byte address is four times the index.
    localparam logic [7:0] gpr_bank_guard_idx = 8'h07;
    localparam logic [7:0] irq_status_idx     = 8'h20;
    localparam logic [7:0] irq_mask_idx       = 8'h21;
    localparam logic [7:0] viol_count_idx     = 8'h22;
    localparam logic [7:0] halt_exempt_idx    = 8'h23;

    // Reset values.
    localparam logic [15:0] bank_guard_reset = 16'h0000;
    localparam logic [3:0]  irq_reset        = 4'h0;

    // Field positions and limits.
    localparam int          bank_msb        = 7;
    localparam int          bank_lsb        = 4;
    localparam logic [7:0]  spr_user_max    = 8'h7f;
    localparam logic [7:0]  spr_virt_min    = 8'ha0;
    localparam logic [7:0]  vector_user_max = 8'h3f;
    localparam logic [7:0]  gpr_first       = 8'h02;
    localparam logic [7:0]  local_base      = 8'h80;

    // Interrupt status bit positions.
    localparam int irq_gpr  = 0;
    localparam int irq_spr  = 1;
    localparam int irq_op   = 2;
    localparam int irq_vect = 3;

    // Instruction classes presented by decode.
    typedef enum logic [2:0] {
        op_plain     = 3'h0,
        op_int_ret   = 3'h1,
        op_ret_inv   = 3'h2,
        op_inval     = 3'h3,
        op_halt      = 3'h4,
        op_trap_vec  = 3'h5
    } op_class_t;

    // One register operand as named by the instruction.
    typedef struct packed {
        logic       used;
        logic       is_local;
        logic [6:0] num;
    } gpr_ref_t;

    // Everything decode hands over for one instruction.
    typedef struct packed {
        logic       valid;
        op_class_t  op;
        gpr_ref_t   src_a;
        gpr_ref_t   src_b;
        gpr_ref_t   dst;
        logic       spr_used;
        logic [7:0] spr_num;
        logic [7:0] vector;
    } decode_req_t;

    // Verdict handed to the trap logic.
    typedef struct packed {
        logic valid;
        logic trap;
        logic commit;
    } verdict_t;

endpackage

/* dv/trap_sink.sv */
// Stand-in for the trap sequencer: counts verdicts that ask for a trap.
// Assumes verdicts are one-cycle pulses on mclk.
`timescale 1ns/10ps
`default_nettype none
module trap_sink (
    // Clock and reset.
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Verdict from the checker.
    input  wire priv_check_pkg::verdict_t verdict,
    output logic [15:0]                   trap_count
);
    // Every trap pulse starts one trap sequence.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trap_count <= 16'h0;
        end else if (verdict.valid && verdict.trap) begin
            trap_count <= trap_count + 16'h1;
        end
    end
endmodule
`default_nettype wire

/* dv/priv_checker.sv */
// Port assertions for the privilege checker.
// Assumes one mclk domain reset by rst_n.
`timescale 1ns/10ps
`default_nettype none
module priv_checker (
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire logic                        supervisor_flag,
    input wire logic [7:0]                  stack_ptr,
    input wire logic                        halt_debug_exempt,
    input wire priv_check_pkg::decode_req_t req,
    input wire priv_check_pkg::verdict_t    verdict,
    input wire logic [7:0]                  reg_addr,
    input wire logic [31:0]                 reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [31:0]                 reg_rdata,
    input wire logic                        irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // A request issued in user mode.
    logic usr;
    assign usr = req.valid && !supervisor_flag;
    chk_verdict_timing: assert property (
        verdict.valid == $past(req.valid)) else $error("verdict late");
    chk_commit_pair: assert property (
        verdict.valid |-> verdict.commit != verdict.trap)
        else $error("commit and trap clash");
    chk_spr_virtual: assert property (
        req.valid && req.spr_used && req.spr_num >= priv_check_pkg::spr_virt_min
        |=> verdict.trap) else $error("high special register not trapped");
    chk_super_free: assert property (
        req.valid && supervisor_flag && !(req.spr_used
        && req.spr_num >= priv_check_pkg::spr_virt_min) |=> !verdict.trap)
        else $error("supervisor request trapped");
    chk_user_priv_op: assert property (
        usr && req.op inside {priv_check_pkg::op_int_ret,
        priv_check_pkg::op_ret_inv, priv_check_pkg::op_inval}
        |=> verdict.trap) else $error("privileged op not trapped");
    chk_user_spr: assert property (
        usr && req.spr_used && req.spr_num <= priv_check_pkg::spr_user_max
        |=> verdict.trap) else $error("low special register not trapped");
    chk_user_vector: assert property (
        usr && req.op == priv_check_pkg::op_trap_vec
        && req.vector <= priv_check_pkg::vector_user_max |=> verdict.trap)
        else $error("low vector not trapped");
    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside slot");
endmodule
bind register_privilege_checker priv_checker u_priv_checker (.mclk, .rst_n,
    .supervisor_flag, .stack_ptr, .halt_debug_exempt, .req, .verdict,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the privilege checker and its registers.
// Assumes the package, the design, the sink and the checker compile first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                        mclk, rst_n, supervisor_flag, irq;
    logic                        halt_debug_exempt, reg_wr, reg_rd;
    logic [7:0]                  stack_ptr, reg_addr;
    logic [31:0]                 reg_wdata, reg_rdata;
    logic [15:0]                 trap_count;
    priv_check_pkg::decode_req_t req;
    priv_check_pkg::verdict_t    verdict;
    int                          err_total, checks, cyc, n_trap;
    register_privilege_checker u_register_privilege_checker (.mclk, .rst_n,
        .supervisor_flag, .stack_ptr, .halt_debug_exempt, .req, .verdict,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    trap_sink u_trap_sink (.mclk, .rst_n, .verdict, .trap_count);
    always #4 mclk = ~mclk;
    // Cuts a hung run short.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            results();
        end
    end
    task automatic results();
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, exp);
    endtask
    // Builds one decode request; the second source stays unused.
    function automatic priv_check_pkg::decode_req_t mk(input logic [2:0] o,
        input logic [8:0] a, input logic [8:0] d, input logic [8:0] s,
        input logic [7:0] v);
        mk = {1'b0, o, a, 9'h0, d, s, v};
    endfunction
    // Issues one request and judges the verdict that follows it.
    task automatic go(input priv_check_pkg::decode_req_t r, input logic t);
        r.valid = 1'b1;
        @(posedge mclk);
        req <= r;
        @(posedge mclk);
        req <= '0;
        #1 cmp({31'h0, verdict.trap}, {31'h0, t});
        n_trap += t;
    endtask
    task automatic t_super();
        wr(priv_check_pkg::gpr_bank_guard_idx, 32'hffff_a5a5);
        rd(priv_check_pkg::gpr_bank_guard_idx, 32'h0000_a5a5);
        rd(8'h10, 32'h0);
        wr(priv_check_pkg::gpr_bank_guard_idx, 32'h0000_ffff);
        supervisor_flag <= 1'b1;
        go(mk(3'h1, 9'h150, 9'h105, 9'h100, 8'h0), 1'b0);
        go(mk(3'h0, 9'h0, 9'h0, 9'h1a0, 8'h0), 1'b1);
        go(mk(3'h0, 9'h0, 9'h0, 9'h1ff, 8'h0), 1'b1);
    endtask
    task automatic t_user();
        supervisor_flag <= 1'b0;
        wr(priv_check_pkg::gpr_bank_guard_idx, 32'h0);
        go(mk(3'h0, 9'h150, 9'h0, 9'h19f, 8'h0), 1'b0);
        for (int i = 1; i < 5; i++) go(mk(i[2:0], 9'h0, 9'h0, 9'h0, 8'h0), 1'b1);
        halt_debug_exempt <= 1'b1;
        go(mk(3'h4, 9'h0, 9'h0, 9'h0, 8'h0), 1'b0);
        halt_debug_exempt <= 1'b0;
        go(mk(3'h0, 9'h0, 9'h0, 9'h17f, 8'h0), 1'b1);
        go(mk(3'h0, 9'h0, 9'h0, 9'h180, 8'h0), 1'b0);
        go(mk(3'h5, 9'h0, 9'h0, 9'h0, 8'h3f), 1'b1);
        go(mk(3'h5, 9'h0, 9'h0, 9'h0, 8'h40), 1'b0);
    endtask
    task automatic t_bank();
        wr(priv_check_pkg::gpr_bank_guard_idx, 32'h0000_0021);
        go(mk(3'h0, 9'h101, 9'h0, 9'h0, 8'h0), 1'b0);
        go(mk(3'h0, 9'h102, 9'h0, 9'h0, 8'h0), 1'b1);
        go(mk(3'h0, 9'h14f, 9'h0, 9'h0, 8'h0), 1'b0);
        go(mk(3'h0, 9'h0, 9'h150, 9'h0, 8'h0), 1'b1);
        wr(priv_check_pkg::gpr_bank_guard_idx, 32'h0000_0400);
        stack_ptr <= 8'h10;
        go(mk(3'h0, 9'h190, 9'h0, 9'h0, 8'h0), 1'b1);
        stack_ptr <= 8'h00;
        go(mk(3'h0, 9'h190, 9'h0, 9'h0, 8'h0), 1'b0);
    endtask
    task automatic t_irq();
        wr(priv_check_pkg::irq_status_idx, 32'hf);
        go(mk(3'h0, 9'h0, 9'h1a0, 9'h0, 8'h0), 1'b1);
        repeat (2) @(posedge mclk);
        #1 cmp({31'h0, irq}, 32'h0);
        rd(priv_check_pkg::irq_status_idx, 32'h1);
        wr(priv_check_pkg::irq_mask_idx, 32'h1);
        repeat (2) @(posedge mclk);
        #1 cmp({31'h0, irq}, 32'h1);
        wr(priv_check_pkg::irq_status_idx, 32'h1);
        repeat (2) @(posedge mclk);
        #1 cmp({31'h0, irq}, 32'h0);
        // Software halt exemption, then the count of trapped requests.
        wr(priv_check_pkg::halt_exempt_idx, 32'h1);
        go(mk(3'h4, 9'h0, 9'h0, 9'h0, 8'h0), 1'b0);
        wr(priv_check_pkg::halt_exempt_idx, 32'h0);
        go(mk(3'h4, 9'h0, 9'h0, 9'h0, 8'h0), 1'b1);
        rd(priv_check_pkg::viol_count_idx, 32'hd);
    endtask
    initial begin
        {mclk, rst_n, supervisor_flag, halt_debug_exempt} = 4'h0;
        {reg_wr, reg_rd, stack_ptr, reg_addr, reg_wdata} = '0;
        req = '0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(priv_check_pkg::gpr_bank_guard_idx, 32'h0);
        t_super();
        t_user();
        t_bank();
        t_irq();
        cmp({16'h0, trap_count}, n_trap);
        results();
    end
endmodule
`default_nettype wire
